// [include/irdp_pkg.sv]
package irdp_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int unsigned REG_ADDR_W = 12;
  localparam logic [11:0] SELECT_OFFSET  = 12'h024;
  localparam logic [11:0] COMMAND_OFFSET = 12'h028;
  localparam logic [11:0] ADDRESS_OFFSET = 12'h02C;
  localparam logic [11:0] WORD_OFFSET    = 12'h030;
  localparam logic [11:0] STATUS_OFFSET  = 12'h034;

  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W         = 32;
  localparam int unsigned READY_BIT      = 31;
  localparam int unsigned SEL_LSB        = 0;
  localparam int unsigned SEL_W          = 4;
  localparam int unsigned CMD_WRITE_BIT  = 0;
  localparam int unsigned RAM_ADDR_W     = 14;
  localparam int unsigned TIMEOUT_BIT    = 0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [3:0]  SEL_RESET     = 4'h0;
  localparam logic        CMD_RESET     = 1'b0;
  localparam logic [13:0] ADDRESS_RESET = 14'h0000;
  localparam logic [31:0] WORD_RESET    = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Target RAM codes
  // ---------------------------------------------------------------
  localparam int unsigned RAM_SLOTS = 8;
  localparam logic [3:0] SEL_RX_BUFFER   = 4'h0;
  localparam logic [3:0] SEL_VLAN_HASH   = 4'h1;
  localparam logic [3:0] SEL_HEADER      = 4'h2;
  localparam logic [3:0] SEL_RX_FIFO_CTL = 4'h3;
  localparam logic [3:0] SEL_TX_FIFO_CTL = 4'h4;
  localparam logic [3:0] SEL_DESCRIPTOR  = 4'h5;
  localparam logic [3:0] SEL_TX_BUFFER   = 4'h7;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned ACCESS_TIMEOUT_CYCLES = 1024;

  typedef enum logic [0:0] {
    IRDP_IDLE = 1'b0,
    IRDP_BUSY = 1'b1
  } irdp_state_t;

  function automatic logic irdp_sel_valid(input logic [3:0] sel);
    return (sel <= SEL_DESCRIPTOR) || (sel == SEL_TX_BUFFER);
  endfunction

endpackage

// [src/irdp_data_port.sv]
// Summary of operation
// - Bit 31 of the select register is a read-only ready flag for the last RAM access.
// - The ready flag is one when idle, zero while busy, and one after reset.
// - A read keeps ready low until the fetched word sits in the word register.
// - The 4-bit selector picks the target RAM; codes 6 and 8 to 15 are reserved.
// - A write to the command register while idle starts one transaction; one while busy is dropped.
// - Command bit zero written as one makes a RAM write, as zero a RAM read.
// - The address register holds a 14-bit word address, upper bits zero, reset zero.
// - The 32-bit word register feeds writes, takes read results, and resets to zero.
// - The selector is read/write and resets to the receive buffer code.
module irdp_data_port import irdp_pkg::*; #(
  parameter int unsigned TIMEOUT_CYCLES = ACCESS_TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic                        clk_sys_i,
  input  wire logic                        reset_i,
  // Register port
  input  wire logic [REG_ADDR_W-1:0]       reg_addr_i,
  input  wire logic [DATA_W-1:0]           reg_wdata_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  output logic      [DATA_W-1:0]           reg_rdata_o,
  // Internal RAM side
  output logic      [RAM_SLOTS-1:0]        ram_req_o,
  output logic                             ram_wr_o,
  output logic      [RAM_ADDR_W-1:0]       ram_addr_o,
  output logic      [DATA_W-1:0]           ram_wdata_o,
  input  wire logic [RAM_SLOTS-1:0]        ram_ack_i,
  input  wire logic [RAM_SLOTS*DATA_W-1:0] ram_rdata_i,
  // Status
  output logic                             port_ready_flag_o
);

  localparam int unsigned TIMER_W = $clog2(TIMEOUT_CYCLES);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (TIMEOUT_CYCLES < 2) begin : g_bad_timeout
    $error("TIMEOUT_CYCLES must be at least 2");
  end

  typedef struct packed {
    irdp_state_t           state;
    logic [SEL_W-1:0]      sel;
    logic                  cmd_write;
    logic [RAM_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]     word;
    logic [SEL_W-1:0]      ram_sel;
    logic                  ram_wr;
    logic [RAM_ADDR_W-1:0] ram_addr;
    logic [DATA_W-1:0]     ram_wdata;
    logic [TIMER_W-1:0]    timer;
    logic                  timed_out;
    logic [DATA_W-1:0]     rdata;
  } irdp_regs_t;

  irdp_regs_t        st;
  irdp_regs_t        next_st;
  logic              busy;
  logic              cmd_start;
  logic              mux_ack;
  logic [DATA_W-1:0] mux_rdata;

  // ---------------------------------------------------------------
  // Target select and answer
  // ---------------------------------------------------------------
  irdp_ram_mux u_mux (
    .sel_i   (st.ram_sel),
    .busy_i  (busy),
    .req_o   (ram_req_o),
    .ack_i   (ram_ack_i),
    .rdata_i (ram_rdata_i),
    .ack_o   (mux_ack),
    .rdata_o (mux_rdata)
  );

  assign busy      = (st.state == IRDP_BUSY);
  assign cmd_start = reg_wr_i && (reg_addr_i == COMMAND_OFFSET) && !busy;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st       = st;
    next_st.rdata = '0;

    // Read data stand only in the cycle after the strobe
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        SELECT_OFFSET: begin
          next_st.rdata[READY_BIT]            = !busy;
          next_st.rdata[SEL_LSB +: SEL_W]     = st.sel;
        end
        COMMAND_OFFSET: begin
          next_st.rdata[CMD_WRITE_BIT]        = st.cmd_write;
        end
        ADDRESS_OFFSET: begin
          next_st.rdata[RAM_ADDR_W-1:0]       = st.addr;
        end
        WORD_OFFSET: begin
          next_st.rdata                       = st.word;
        end
        STATUS_OFFSET: begin
          next_st.rdata[TIMEOUT_BIT]          = st.timed_out;
        end
        default: begin
          next_st.rdata                       = '0;
        end
      endcase
    end

    if (reg_wr_i) begin
      unique case (reg_addr_i)
        SELECT_OFFSET: begin
          next_st.sel = reg_wdata_i[SEL_LSB +: SEL_W];
        end
        COMMAND_OFFSET: begin
          // A command during a transaction is dropped whole
          if (!busy) begin
            next_st.cmd_write = reg_wdata_i[CMD_WRITE_BIT];
          end
        end
        ADDRESS_OFFSET: begin
          next_st.addr = reg_wdata_i[RAM_ADDR_W-1:0];
        end
        WORD_OFFSET: begin
          next_st.word = reg_wdata_i;
        end
        STATUS_OFFSET: begin
          if (reg_wdata_i[TIMEOUT_BIT]) begin
            next_st.timed_out = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    unique case (st.state)
      IRDP_IDLE: begin
        // any command write starts a transaction
        if (cmd_start) begin
          next_st.state     = IRDP_BUSY;
          next_st.ram_wr    = reg_wdata_i[CMD_WRITE_BIT];
          next_st.ram_sel   = st.sel;
          next_st.ram_addr  = st.addr;
          next_st.ram_wdata = st.word;
          next_st.timer     = '0;
        end
      end
      IRDP_BUSY: begin
        next_st.timer = st.timer + 1'b1;
        if (mux_ack) begin
          // word loaded in the same edge that frees ready
          next_st.state = IRDP_IDLE;
          if (!st.ram_wr) begin
            next_st.word = mux_rdata;
          end
        end else if (st.timer == TIMER_W'(TIMEOUT_CYCLES - 1)) begin
          // A silent RAM must not hang the port for ever
          next_st.state     = IRDP_IDLE;
          next_st.timed_out = 1'b1;
          if (!st.ram_wr) begin
            next_st.word = '0;
          end
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      // idle, so ready, out of reset
      st <= '{state:     IRDP_IDLE,
              sel:       SEL_RESET,
              cmd_write: CMD_RESET,
              addr:      ADDRESS_RESET,
              word:      WORD_RESET,
              ram_sel:   SEL_RESET,
              ram_wr:    1'b0,
              ram_addr:  ADDRESS_RESET,
              ram_wdata: WORD_RESET,
              timer:     '0,
              timed_out: 1'b0,
              rdata:     WORD_RESET};
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata_o       = st.rdata;
  assign ram_wr_o          = st.ram_wr;
  assign ram_addr_o        = st.ram_addr;
  assign ram_wdata_o       = st.ram_wdata;
  assign port_ready_flag_o = !busy;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  chk_ready_drops_next:
    assert property (cmd_start |=> !port_ready_flag_o)
      else $error("ready did not fall after a command write");

  chk_ready_tracks_idle:
    assert property ((st.state == IRDP_IDLE && !cmd_start) |=> port_ready_flag_o)
      else $error("ready dropped with no command");

  chk_read_loads_word:
    assert property ((busy && !st.ram_wr && mux_ack) |=>
                     (port_ready_flag_o && st.word == $past(mux_rdata)))
      else $error("read result not in word register at ready");

  chk_direction_bit:
    assert property (cmd_start |=> (ram_wr_o == $past(reg_wdata_i[CMD_WRITE_BIT])))
      else $error("transaction direction differs from command bit");

  chk_request_onehot:
    assert property ($onehot0(ram_req_o) && (busy || ram_req_o == '0))
      else $error("bad RAM request vector");

  chk_addr_held_busy:
    assert property ((busy && $past(busy)) |-> ($stable(ram_addr_o) && $stable(ram_wdata_o)))
      else $error("RAM address or data moved mid access");

  chk_write_data_source:
    assert property (cmd_start |=> (ram_wdata_o == $past(st.word) && ram_addr_o == $past(st.addr)))
      else $error("RAM write data or address not taken from registers");

  chk_select_readback:
    assert property ((reg_wr_i && reg_addr_i == SELECT_OFFSET) ##1
                     (reg_rd_i && reg_addr_i == SELECT_OFFSET) |=>
                     reg_rdata_o[SEL_LSB +: SEL_W] == $past(reg_wdata_i[SEL_LSB +: SEL_W], 2))
      else $error("selector readback wrong");

  chk_ready_in_readback:
    assert property ((reg_rd_i && reg_addr_i == SELECT_OFFSET) |=>
                     (reg_rdata_o[READY_BIT] == $past(port_ready_flag_o) &&
                      reg_rdata_o[30:4] == '0))
      else $error("ready flag or reserved bits wrong in select readback");

  chk_address_upper_zero:
    assert property ((reg_rd_i && reg_addr_i == ADDRESS_OFFSET) |=>
                     reg_rdata_o[DATA_W-1:RAM_ADDR_W] == '0)
      else $error("reserved address bits not zero");

  chk_access_bounded:
    assert property ((busy && st.timer == TIMER_W'(TIMEOUT_CYCLES - 1)) |=> !busy)
      else $error("access ran past its time limit");

  chk_timeout_flag_set:
    assert property ((busy && !mux_ack && st.timer == TIMER_W'(TIMEOUT_CYCLES - 1)) |=> st.timed_out)
      else $error("timed-out access left no status flag");

  chk_busy_cmd_dropped:
    assert property ((busy && reg_wr_i && reg_addr_i == COMMAND_OFFSET) |=> $stable(st.cmd_write))
      else $error("command taken while busy");

  chk_reserved_quick:
    assert property ((busy && !irdp_sel_valid(st.ram_sel)) |-> (ram_req_o == '0) ##1 !busy)
      else $error("reserved selector made a request or stalled");

endmodule

// [src/irdp_ram_mux.sv]
module irdp_ram_mux import irdp_pkg::*; (
  // Transaction state
  input  wire logic [3:0]                  sel_i,
  input  wire logic                        busy_i,
  // Target RAM handshake
  output logic      [RAM_SLOTS-1:0]        req_o,
  input  wire logic [RAM_SLOTS-1:0]        ack_i,
  input  wire logic [RAM_SLOTS*DATA_W-1:0] rdata_i,
  // Selected answer
  output logic                             ack_o,
  output logic      [DATA_W-1:0]           rdata_o
);

  logic valid;

  // ---------------------------------------------------------------
  // Decode and answer select
  // ---------------------------------------------------------------
  always_comb begin
    valid   = irdp_sel_valid(sel_i);
    req_o   = '0;
    ack_o   = 1'b0;
    rdata_o = '0;
    if (busy_i) begin
      if (valid) begin
        req_o[sel_i[2:0]] = 1'b1;
        ack_o             = ack_i[sel_i[2:0]];
        rdata_o           = rdata_i[sel_i[2:0]*DATA_W +: DATA_W];
      end else begin
        // Reserved code: nothing to wait for, read answers zero
        ack_o = 1'b1;
      end
    end
  end

endmodule

// [verification/irdp_data_port_test.sv]
module irdp_data_port_test import irdp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  typedef struct {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rexp;
  } irdp_row_t;

  logic                        clk_sys_i;
  logic                        reset_i;
  logic [REG_ADDR_W-1:0]       reg_addr_i;
  logic [DATA_W-1:0]           reg_wdata_i;
  logic                        reg_wr_i;
  logic                        reg_rd_i;
  logic [DATA_W-1:0]           reg_rdata_o;
  logic [RAM_SLOTS-1:0]        ram_req_o;
  logic                        ram_wr_o;
  logic [RAM_ADDR_W-1:0]       ram_addr_o;
  logic [DATA_W-1:0]           ram_wdata_o;
  logic [RAM_SLOTS-1:0]        ram_ack_i;
  logic [RAM_SLOTS*DATA_W-1:0] ram_rdata_i;
  logic                        port_ready_flag_o;
  logic [31:0]                 got;
  int                          err_total;
  int                          n_tests;
  logic [3:0]                  rsv [3] = '{4'h6, 4'h8, 4'hF};
  irdp_row_t                   rows [8] = '{
    '{SELECT_OFFSET,  32'hFFFF_FFF5, 32'h8000_0005},
    '{SELECT_OFFSET,  32'h7FFF_FFF0, 32'h8000_0000},
    '{ADDRESS_OFFSET, 32'hFFFF_FFFF, 32'h0000_3FFF},
    '{ADDRESS_OFFSET, 32'h0000_2A55, 32'h0000_2A55},
    '{WORD_OFFSET,    32'hDEAD_BEEF, 32'hDEAD_BEEF},
    '{WORD_OFFSET,    32'h0000_0000, 32'h0000_0000},
    '{12'h100,        32'hFFFF_FFFF, 32'h0000_0000},
    '{12'h020,        32'hFFFF_FFFF, 32'h0000_0000}};

  // Long counts shortened so a stalled access still ends quickly
  irdp_data_port #(.TIMEOUT_CYCLES(64)) DUT (
    .clk_sys_i         (clk_sys_i),
    .reset_i           (reset_i),
    .reg_addr_i        (reg_addr_i),
    .reg_wdata_i       (reg_wdata_i),
    .reg_wr_i          (reg_wr_i),
    .reg_rd_i          (reg_rd_i),
    .reg_rdata_o       (reg_rdata_o),
    .ram_req_o         (ram_req_o),
    .ram_wr_o          (ram_wr_o),
    .ram_addr_o        (ram_addr_o),
    .ram_wdata_o       (ram_wdata_o),
    .ram_ack_i         (ram_ack_i),
    .ram_rdata_i       (ram_rdata_i),
    .port_ready_flag_o (port_ready_flag_o)
  );

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] val, input logic [31:0] exp);
    n_tests++;
    if (val !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, val, exp);
    end
  endtask

  task automatic reg_write(input logic [11:0] addr, input logic [31:0] data);
    @(posedge clk_sys_i);
    reg_addr_i  <= addr;
    reg_wdata_i <= data;
    reg_wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic reg_read(input logic [11:0] addr, output logic [31:0] data);
    @(posedge clk_sys_i);
    reg_addr_i <= addr;
    reg_rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b0;
    #1 data = reg_rdata_o;
  endtask

  // Word register ends equal to data: written value, or the RAM answer of a read
  task automatic run_access(input logic [3:0] sel, input logic wr, input logic [13:0] addr,
                            input logic [31:0] data, input int dly);
    reg_write(SELECT_OFFSET, {28'h000_0000, sel});
    reg_write(ADDRESS_OFFSET, {18'h0_0000, addr});
    reg_write(WORD_OFFSET, wr ? data : 32'h0000_0000);
    reg_write(COMMAND_OFFSET, {31'h0000_0000, wr});
    #1 check(port_ready_flag_o, 32'h0000_0000); // ready drops
    check(ram_req_o, 32'h0000_0001 << sel); // target chosen
    check(ram_wr_o, wr); // direction
    check(ram_addr_o, addr); // address used
    if (wr)
      check(ram_wdata_o, data); // write data used
    repeat (dly) begin
      @(posedge clk_sys_i);
      #1 check(port_ready_flag_o | ram_req_o[sel] << 1, 32'h0000_0002); // busy held
    end
    @(posedge clk_sys_i);
    ram_ack_i[sel]             <= 1'b1;
    ram_rdata_i[32*sel +: 32]  <= data;
    @(posedge clk_sys_i);
    ram_ack_i                  <= 8'h00;
    ram_rdata_i[32*sel +: 32]  <= ~data;
    #1 check(port_ready_flag_o, 32'h0000_0001); // ready after access
    check(ram_req_o, 32'h0000_0000); // request ends
    reg_read(WORD_OFFSET, got);
    check(got, data); // word result
    reg_read(COMMAND_OFFSET, got);
    check(got, {31'h0000_0000, wr}); // direction readback
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    repeat (6000) @(posedge clk_sys_i);
    err_total++;
    stop_test;
  end

  initial begin
    err_total = 0;
    n_tests = 0;
    reset_i = 1'b1;
    reg_addr_i = 12'h000;
    reg_wdata_i = 32'h0000_0000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    ram_ack_i = 8'h00;
    // Distinct idle answers per slot expose a wrong mux choice
    for (int k = 0; k < 8; k++)
      ram_rdata_i[32*k +: 32] = {8{k[3:0]}};
    repeat (4) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    foreach (rows[i]) begin
      reg_write(rows[i].addr, rows[i].wdata);
      reg_read(rows[i].addr, got);
      check(got, rows[i].rexp); // readback
    end
    $display("test registers done");
    for (int k = 0; k < 8; k++) begin
      if (k != 6) begin
        run_access(k[3:0], 1'b1, 14'(16'h3FFF - k), 32'hC0DE_0000 + k, k);
        run_access(k[3:0], 1'b0, 14'(16'h0100 + k), 32'h5EED_0000 + k, 7 - k);
      end
    end
    $display("test accesses done");
    foreach (rsv[i]) begin
      reg_write(SELECT_OFFSET, {28'h000_0000, rsv[i]});
      reg_write(WORD_OFFSET, 32'hFFFF_FFFF);
      reg_write(COMMAND_OFFSET, 32'h0000_0000);
      #1 check(ram_req_o, 32'h0000_0000); // no request
      @(posedge clk_sys_i);
      #1 check(port_ready_flag_o, 32'h0000_0001); // quick return
      reg_read(WORD_OFFSET, got);
      check(got, 32'h0000_0000); // empty result
      reg_read(SELECT_OFFSET, got);
      check(got, {1'b1, 27'h000_0000, rsv[i]}); // code kept
    end
    $display("test reserved done");
    // broken on purpose: a command while busy is dropped
    reg_write(SELECT_OFFSET, 32'h0000_0001);
    reg_write(WORD_OFFSET, 32'hFFFF_FFFF);
    reg_write(COMMAND_OFFSET, 32'h0000_0000);
    reg_write(COMMAND_OFFSET, 32'h0000_0001);
    reg_read(COMMAND_OFFSET, got);
    check(got, 32'h0000_0000); // busy command dropped
    // Silent RAM: limit of 64 busy edges
    repeat (59) @(posedge clk_sys_i);
    #1 check(port_ready_flag_o, 32'h0000_0000); // busy to the limit
    @(posedge clk_sys_i);
    #1 check(port_ready_flag_o, 32'h0000_0001); // limit frees ready
    reg_read(STATUS_OFFSET, got);
    check(got, 32'h0000_0001); // timeout flag set
    reg_read(WORD_OFFSET, got);
    check(got, 32'h0000_0000); // timed-out read empty
    reg_write(STATUS_OFFSET, 32'h0000_0001);
    reg_read(STATUS_OFFSET, got);
    check(got, 32'h0000_0000); // flag cleared
    $display("test timeout done");
    reg_write(SELECT_OFFSET, 32'h0000_0001);
    reg_write(WORD_OFFSET, 32'h1234_5678);
    reg_write(COMMAND_OFFSET, 32'h0000_0000);
    reg_read(SELECT_OFFSET, got);
    check(got, 32'h0000_0001); // busy shows in flag
    reg_read(WORD_OFFSET, got);
    check(got, 32'h1234_5678); // no early result
    @(posedge clk_sys_i);
    ram_ack_i <= 8'h04;
    @(posedge clk_sys_i);
    ram_ack_i <= 8'h00;
    #1 check(port_ready_flag_o, 32'h0000_0000); // foreign ack ignored
    check(ram_req_o, 32'h0000_0002); // request held
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    @(posedge clk_sys_i);
    reset_i <= 1'b0;
    #1 check(port_ready_flag_o, 32'h0000_0001); // ready out of reset
    check(ram_req_o, 32'h0000_0000); // request dropped
    foreach (rows[i]) begin
      if (i < 6 && i % 2 == 0) begin
        reg_read(rows[i].addr, got);
        check(got, i == 0 ? 32'h8000_0000 : 32'h0000_0000); // reset values
      end
    end
    reg_read(COMMAND_OFFSET, got);
    check(got, 32'h0000_0000); // command reset
    $display("test reset done");
    stop_test;
  end
endmodule
